/* verilog/ufc_top.sv */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// FIFO control of an asynchronous serial port
// ---------------------------------------------------------------------------
module ufc_top
  import ufc_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 16,
  parameter int unsigned LVL_W    = $clog2(RX_DEPTH + 1)
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // FIFO status from the data path
  input  wire logic [LVL_W-1:0]  rx_level,
  input  wire logic              rx_empty,
  input  wire logic              tx_empty,
  input  wire logic              tx_full,
  input  wire logic              char_timeout,
  // FIFO control to the data path
  output logic                   fifo_mode,
  output logic                   tx_fifo_clear,
  output logic                   rx_fifo_clear,
  output logic      [1:0]        rx_trigger_level,
  output logic                   rx_trigger_hit,
  output logic      [1:0]        fifo_enabled_status,
  // DMA handshake
  output logic                   dma_multi,
  output logic                   rx_dma_req,
  output logic                   tx_dma_req,
  // Interrupt
  output logic                   irq
);

  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  // The largest threshold must be reachable and the level must fit its port
  generate
    if (RX_DEPTH < 14 || RX_DEPTH > 255) begin : g_bad_depth
      $error("RX_DEPTH must lie between 14 and 255");
    end
    if (LVL_W < $clog2(RX_DEPTH + 1)) begin : g_bad_lvl
      $error("LVL_W too narrow for RX_DEPTH");
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------------
  ufc_bus_t bus;
  ufc_ctl_t wr_ctl;
  logic     fc_wr;
  logic     en_change;

  // Address match used for writes and reads alike
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Pack the bus request and view the low byte as the control layout
  always_comb begin
    bus.addr  = reg_addr;
    bus.wdata = reg_wdata;
    bus.wr    = reg_wr;
    bus.rd    = reg_rd;
    wr_ctl    = ufc_ctl_t'(bus.wdata[7:0]);
    fc_wr     = bus.wr && reg_hit(bus.addr, OFS_FIFO_CONTROL);
    en_change = fc_wr && (wr_ctl.fifo_enable != fifo_mode);
  end

  // -------------------------------------------------------------------------
  // FIFO control state
  // -------------------------------------------------------------------------
  logic       next_fifo_mode;
  logic       next_dma_multi;
  logic [1:0] next_trig;
  logic       next_tx_clear;
  logic       next_rx_clear;

  // Settings update; a write without the enable bit only turns FIFOs off, clearing both if they were on
  always_comb begin
    next_fifo_mode = fifo_mode;
    next_dma_multi = dma_multi;
    next_trig      = rx_trigger_level;
    next_tx_clear  = 1'b0;
    next_rx_clear  = 1'b0;
    if (fc_wr) begin
      next_fifo_mode = wr_ctl.fifo_enable;
      if (wr_ctl.fifo_enable) begin
        next_dma_multi = wr_ctl.dma_mode;
        next_trig      = wr_ctl.rx_trigger_level;
        next_tx_clear  = wr_ctl.tx_reset;
        next_rx_clear  = wr_ctl.rx_reset;
      end
      if (en_change) begin
        next_tx_clear = 1'b1;
        next_rx_clear = 1'b1;
      end
    end
  end

  // Settings and one-cycle clear strobes; the data path FIFOs and the clear interrupt event see them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_mode        <= RST_EN;
      dma_multi        <= RST_DMA;
      rx_trigger_level <= RST_TRIG;
      tx_fifo_clear    <= 1'b0;
      rx_fifo_clear    <= 1'b0;
    end else begin
      fifo_mode        <= next_fifo_mode;
      dma_multi        <= next_dma_multi;
      rx_trigger_level <= next_trig;
      tx_fifo_clear    <= next_tx_clear;
      rx_fifo_clear    <= next_rx_clear;
    end
  end

  // Top two status bits follow the enable; zero in single-character mode
  assign fifo_enabled_status = {fifo_mode, fifo_mode};

  // -------------------------------------------------------------------------
  // Trigger and DMA request logic
  // -------------------------------------------------------------------------
  // Threshold comparison against the receive fill level
  ufc_rx_trigger #(
    .LVL_W            (LVL_W)
  ) u_trigger (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .fifo_mode        (fifo_mode),
    .rx_trigger_level (rx_trigger_level),
    .rx_level         (rx_level),
    .rx_trigger_hit   (rx_trigger_hit)
  );

  // Multi-character bursts only in FIFO mode with the DMA bit set
  ufc_dma_req u_dma (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .multi_mode       (fifo_mode && dma_multi),
    .rx_trigger_hit   (rx_trigger_hit),
    .char_timeout     (char_timeout),
    .rx_empty         (rx_empty),
    .tx_empty         (tx_empty),
    .tx_full          (tx_full),
    .rx_dma_req       (rx_dma_req),
    .tx_dma_req       (tx_dma_req)
  );

  // -------------------------------------------------------------------------
  // Interrupt status and mask
  // -------------------------------------------------------------------------
  logic [IRQ_W-1:0] int_status, next_int_status;
  logic [IRQ_W-1:0] int_mask, next_int_mask;
  logic [IRQ_W-1:0] events;
  logic             hit_d, tmo_d;

  // Rising edges and clear strobes raise sticky bits; a set beats a clear
  always_comb begin
    events              = '0;
    events[IRQ_TRIG]    = rx_trigger_hit && !hit_d;
    events[IRQ_TIMEOUT] = char_timeout && !tmo_d;
    events[IRQ_CLEARED] = tx_fifo_clear || rx_fifo_clear;
    next_int_status     = int_status;
    next_int_mask       = int_mask;
    if (bus.wr && reg_hit(bus.addr, OFS_INT_STATUS)) begin
      next_int_status = int_status & ~bus.wdata[IRQ_W-1:0];
    end
    if (bus.wr && reg_hit(bus.addr, OFS_INT_MASK)) begin
      next_int_mask = bus.wdata[IRQ_W-1:0];
    end
    next_int_status = next_int_status | events;
  end

  // Status, mask and edge history
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_status <= RST_STATUS;
      int_mask   <= RST_MASK;
      hit_d      <= 1'b0;
      tmo_d      <= 1'b0;
    end else begin
      int_status <= next_int_status;
      int_mask   <= next_int_mask;
      hit_d      <= rx_trigger_hit;
      tmo_d      <= char_timeout;
    end
  end

  // Level interrupt while any unmasked bit stands
  assign irq = |(int_status & int_mask);

  // -------------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] state_word;

  // State word: enable mirror on top, live flags low, reserved bits zero
  always_comb begin
    state_word              = '0;
    state_word[ST_TRIG_HIT] = rx_trigger_hit;
    state_word[ST_RX_DMA]   = rx_dma_req;
    state_word[ST_TX_DMA]   = tx_dma_req;
    state_word[ST_DMA_MODE] = fifo_mode && dma_multi;
    state_word[ST_EN_LO]    = fifo_mode;
    state_word[ST_EN_HI]    = fifo_mode;
  end

  // Read mux; the control register and unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    if (bus.rd) begin
      if (reg_hit(bus.addr, OFS_FIFO_STATE)) begin
        next_rdata = state_word;
      end else if (reg_hit(bus.addr, OFS_INT_STATUS)) begin
        next_rdata[IRQ_W-1:0] = int_status;
      end else if (reg_hit(bus.addr, OFS_INT_MASK)) begin
        next_rdata[IRQ_W-1:0] = int_mask;
      end
    end
  end

  // Read data stand in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_ctl_write_only: assert property (
    (reg_rd && reg_addr == OFS_FIFO_CONTROL) |=> (reg_rdata == '0))
    else $error("Control register returned data");

  chk_tx_clear_pulse: assert property (
    (fc_wr && wr_ctl.fifo_enable && wr_ctl.tx_reset) |=> tx_fifo_clear)
    else $error("Transmit clear missing");

  chk_tx_self_clear: assert property (
    (tx_fifo_clear && !fc_wr) |=> !tx_fifo_clear)
    else $error("Transmit clear did not end");

  chk_rx_clear_pulse: assert property (
    (fc_wr && wr_ctl.fifo_enable && wr_ctl.rx_reset) |=> rx_fifo_clear)
    else $error("Receive clear missing");

  chk_rx_self_clear: assert property (
    (rx_fifo_clear && !fc_wr) |=> !rx_fifo_clear)
    else $error("Receive clear did not end");

  chk_enable_sets: assert property (
    (fc_wr && wr_ctl.fifo_enable) |=> fifo_mode ##1 (fifo_mode || $past(fc_wr)))
    else $error("Enable write did not enter FIFO mode");

  chk_ignore_ctl: assert property (
    (fc_wr && !wr_ctl.fifo_enable)
      |=> ($stable(rx_trigger_level) && $stable(dma_multi) && !fifo_mode))
    else $error("Control bits taken without enable");

  chk_change_clears: assert property (
    en_change |=> (tx_fifo_clear && rx_fifo_clear))
    else $error("Enable change did not clear both FIFOs");

  chk_compat_mode: assert property (
    !fifo_mode |-> (fifo_enabled_status == 2'b00) && (rx_dma_req == !rx_empty))
    else $error("Compatibility mode behaviour wrong");

  chk_reserved_zero: assert property (
    (reg_rd && reg_addr == OFS_FIFO_STATE)
      |=> (reg_rdata[31:8] == '0) && (reg_rdata[5:4] == 2'b00)
          && (reg_rdata[7:6] == {2{fifo_mode}}))
    else $error("Reserved or status bits wrong");

  chk_status_mirror: assert property (
    fc_wr |=> (fifo_enabled_status == {2{$past(wr_ctl.fifo_enable)}}))
    else $error("Enable mirror wrong");

  chk_irq_sticky: assert property (
    (events != '0) |=> ((int_status & $past(events)) == $past(events)))
    else $error("Event lost from status");

  // Settings and clear strobes move only on control writes
  chk_settings_hold: assert property (
    !fc_wr |=> ($stable(fifo_mode) && $stable(dma_multi) && $stable(rx_trigger_level)))
    else $error("Setting changed without a write");

  chk_clear_needs_write: assert property (
    !fc_wr |=> (!tx_fifo_clear && !rx_fifo_clear))
    else $error("Clear strobe without a write");

  chk_fields_taken: assert property (
    (fc_wr && wr_ctl.fifo_enable)
      |=> (rx_trigger_level == $past(wr_ctl.rx_trigger_level))
          && (dma_multi == $past(wr_ctl.dma_mode)))
    else $error("Control fields not taken");

  chk_no_stray_clear: assert property (
    (fc_wr && !wr_ctl.fifo_enable && !fifo_mode) |=> (!tx_fifo_clear && !rx_fifo_clear))
    else $error("Clear strobe without enable");

  chk_irq_w1c: assert property (
    (reg_wr && reg_addr == OFS_INT_STATUS && events == '0)
      |=> ((int_status & $past(reg_wdata[IRQ_W-1:0])) == '0))
    else $error("Status bit not cleared by write");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == '0))
    else $error("Read data outside read cycle");

  cov_fifo_on: cover property (fc_wr && wr_ctl.fifo_enable ##1 tx_fifo_clear);
  cov_multi_dma: cover property (fifo_mode && dma_multi && rx_dma_req);
  cov_irq: cover property (irq ##1 !irq);
  cov_tmo_burst: cover property (char_timeout && !rx_trigger_hit ##1 rx_dma_req);

endmodule

/* verilog/ufc_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants and types of the FIFO control block
// ---------------------------------------------------------------------------
package ufc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h08;
  localparam logic [7:0] OFS_FIFO_STATE   = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS   = 8'h20;
  localparam logic [7:0] OFS_INT_MASK     = 8'h24;

  // Field positions inside the read-only state word
  localparam int unsigned ST_TRIG_HIT = 0;
  localparam int unsigned ST_RX_DMA   = 1;
  localparam int unsigned ST_TX_DMA   = 2;
  localparam int unsigned ST_DMA_MODE = 3;
  localparam int unsigned ST_EN_LO    = 6;
  localparam int unsigned ST_EN_HI    = 7;

  // Interrupt event positions
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_TRIG    = 0;
  localparam int unsigned IRQ_TIMEOUT = 1;
  localparam int unsigned IRQ_CLEARED = 2;

  // Values after reset
  localparam logic [1:0]       RST_TRIG   = 2'h0;
  localparam logic             RST_DMA    = 1'b0;
  localparam logic             RST_EN     = 1'b0;
  localparam logic [IRQ_W-1:0] RST_STATUS = 3'h0;
  localparam logic [IRQ_W-1:0] RST_MASK   = 3'h0;

  // Receive trigger thresholds in bytes
  localparam logic [4:0] TRIG_SEL00 = 5'h01;
  localparam logic [4:0] TRIG_SEL01 = 5'h04;
  localparam logic [4:0] TRIG_SEL10 = 5'h08;
  localparam logic [4:0] TRIG_SEL11 = 5'h0E;

  // Layout of the write-only FIFO control byte
  typedef struct packed {
    logic [1:0] rx_trigger_level;
    logic [1:0] reserved;
    logic       dma_mode;
    logic       tx_reset;
    logic       rx_reset;
    logic       fifo_enable;
  } ufc_ctl_t;

  // One register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ufc_bus_t;

  // DMA burst tracking state
  typedef enum logic [1:0] {
    DMA_IDLE  = 2'b00,
    DMA_BURST = 2'b01
  } ufc_dma_state_t;

  // Threshold in bytes for a trigger selection
  function automatic logic [4:0] ufc_trig_bytes(input logic [1:0] sel);
    case (sel)
      2'b00:   ufc_trig_bytes = TRIG_SEL00;
      2'b01:   ufc_trig_bytes = TRIG_SEL01;
      2'b10:   ufc_trig_bytes = TRIG_SEL10;
      default: ufc_trig_bytes = TRIG_SEL11;
    endcase
  endfunction

endpackage

/* verilog/ufc_rx_trigger.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Receive trigger level comparator
// ---------------------------------------------------------------------------
module ufc_rx_trigger
  import ufc_pkg::*;
#(
  parameter int unsigned LVL_W = 5
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Settings
  input  wire logic             fifo_mode,
  input  wire logic [1:0]       rx_trigger_level,
  // Receive FIFO fill
  input  wire logic [LVL_W-1:0] rx_level,
  // Result
  output logic                  rx_trigger_hit
);

  logic [LVL_W-1:0] threshold;
  logic             next_hit;

  // The largest threshold of fourteen bytes needs four bits
  generate
    if (LVL_W < 4) begin : g_bad_lvl
      $error("LVL_W must be at least 4");
    end
  endgenerate

  // Threshold follows the selected level; single-character mode needs one byte
  always_comb begin
    threshold = LVL_W'(ufc_trig_bytes(rx_trigger_level));
    if (fifo_mode) begin
      next_hit = (rx_level >= threshold);
    end else begin
      next_hit = (rx_level != '0);
    end
  end

  // Registered flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_trigger_hit <= 1'b0;
    end else begin
      rx_trigger_hit <= next_hit;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_trig_threshold: assert property (
    (fifo_mode && rx_level >= LVL_W'(ufc_trig_bytes(rx_trigger_level)))
      |=> rx_trigger_hit)
    else $error("Trigger flag missed its threshold");

endmodule

/* verilog/ufc_dma_req.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// DMA request signalling, single-character or multi-character
// ---------------------------------------------------------------------------
module ufc_dma_req
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Mode
  input  wire logic multi_mode,
  // Receive side status
  input  wire logic rx_trigger_hit,
  input  wire logic char_timeout,
  input  wire logic rx_empty,
  // Transmit side status
  input  wire logic tx_empty,
  input  wire logic tx_full,
  // Requests
  output logic      rx_dma_req,
  output logic      tx_dma_req
);

  ufc_dma_state_t rx_state, next_rx_state;
  ufc_dma_state_t tx_state, next_tx_state;

  // Burst start and end for both directions
  always_comb begin
    next_rx_state = rx_state;
    next_tx_state = tx_state;
    case (rx_state)
      DMA_IDLE:  if (multi_mode && (rx_trigger_hit || char_timeout)) next_rx_state = DMA_BURST;
      DMA_BURST: if (!multi_mode || rx_empty) next_rx_state = DMA_IDLE;
      default:   next_rx_state = DMA_IDLE;
    endcase
    case (tx_state)
      DMA_IDLE:  if (multi_mode && tx_empty) next_tx_state = DMA_BURST;
      DMA_BURST: if (!multi_mode || tx_full) next_tx_state = DMA_IDLE;
      default:   next_tx_state = DMA_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= DMA_IDLE;
      tx_state <= DMA_IDLE;
    end else begin
      rx_state <= next_rx_state;
      tx_state <= next_tx_state;
    end
  end

  // Requests: burst-wide in multi mode, per character otherwise
  assign rx_dma_req = multi_mode ? (rx_state == DMA_BURST && !rx_empty) : !rx_empty;
  assign tx_dma_req = multi_mode ? (tx_state == DMA_BURST && !tx_full) : tx_empty;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_rx_burst_start: assert property (
    (multi_mode && rx_state == DMA_IDLE && (rx_trigger_hit || char_timeout))
      |=> (rx_state == DMA_BURST))
    else $error("Receive burst did not start");

  chk_burst_holds: assert property (
    (multi_mode && rx_state == DMA_BURST && !rx_empty) ##1 (multi_mode && !rx_empty)
      |-> rx_dma_req)
    else $error("Receive burst dropped before empty");

  chk_single_char: assert property (
    !multi_mode |-> (rx_dma_req == !rx_empty) && (tx_dma_req == tx_empty))
    else $error("Single-character requests wrong");

  cov_rx_burst: cover property (multi_mode && rx_dma_req [*3] ##1 rx_empty);

endmodule

/* verif/ufc_dp_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Data path stand-in: fill counts of both FIFOs, fed by bench and DMA
// ---------------------------------------------------------------------------
module ufc_dp_model
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Bench commands
  input  wire logic       rx_push,
  input  wire logic       dma_on,
  // Control from the block
  input  wire logic       tx_fifo_clear,
  input  wire logic       rx_fifo_clear,
  input  wire logic       rx_dma_req,
  input  wire logic       tx_dma_req,
  // Status to the block
  output logic      [4:0] rx_level,
  output logic      [4:0] tx_level,
  output logic            rx_empty,
  output logic            tx_empty,
  output logic            tx_full
);
  // Counts; a clear wins over a push or a DMA move in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_level <= 5'h00;
      tx_level <= 5'h00;
    end else begin
      if (rx_fifo_clear) begin
        rx_level <= 5'h00;
      end else if (rx_push) begin
        rx_level <= rx_level + 5'h01;
      end else if (dma_on && rx_dma_req && !rx_empty) begin
        rx_level <= rx_level - 5'h01; // DMA reads one byte
      end
      if (tx_fifo_clear) begin
        tx_level <= 5'h00;
      end else if (dma_on && tx_dma_req && !tx_full) begin
        tx_level <= tx_level + 5'h01; // DMA writes one byte
      end
    end
  end

  // Flags derived from the counts
  assign rx_empty = (rx_level == 5'h00);
  assign tx_empty = (tx_level == 5'h00);
  assign tx_full  = (tx_level == 5'h10);
endmodule

/* verif/tb_uart_fifo_control.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Bench of the FIFO control block
// ---------------------------------------------------------------------------
module tb_uart_fifo_control;
  import ufc_pkg::*;
  logic        sys_clk, resetn, reg_wr, reg_rd, rx_push, dma_on, char_timeout;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [4:0]  rx_level, tx_level;
  logic        rx_empty, tx_empty, tx_full, fifo_mode, tx_fifo_clear, rx_fifo_clear;
  logic        rx_trigger_hit, dma_multi, rx_dma_req, tx_dma_req, irq;
  logic [1:0]  rx_trigger_level, fifo_enabled_status;
  logic [4:0]  thr [4];
  int          fails, n_checks, n_txc, n_rxc;

  ufc_top dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_level(rx_level),
    .rx_empty(rx_empty), .tx_empty(tx_empty), .tx_full(tx_full),
    .char_timeout(char_timeout), .fifo_mode(fifo_mode), .tx_fifo_clear(tx_fifo_clear),
    .rx_fifo_clear(rx_fifo_clear), .rx_trigger_level(rx_trigger_level),
    .rx_trigger_hit(rx_trigger_hit), .fifo_enabled_status(fifo_enabled_status),
    .dma_multi(dma_multi), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .irq(irq));

  ufc_dp_model model (
    .sys_clk(sys_clk), .resetn(resetn), .rx_push(rx_push), .dma_on(dma_on),
    .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .rx_level(rx_level),
    .tx_level(tx_level), .rx_empty(rx_empty), .tx_empty(tx_empty), .tx_full(tx_full));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Counts clear pulses seen on the control outputs
  always @(posedge sys_clk) begin
    if (tx_fifo_clear === 1'b1) n_txc++;
    if (rx_fifo_clear === 1'b1) n_rxc++;
  end

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Pushes n received bytes, one per cycle
  task push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk) rx_push <= 1'b1;
    end
    @(posedge sys_clk) rx_push <= 1'b0;
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(25 * 20000);
    fails++;
    wrap_up();
  end

  // Main sequence; software keeps bits 31 to 8 zero in every write
  initial begin
    thr = '{5'h01, 5'h04, 5'h08, 5'h0E};
    {resetn, reg_wr, reg_rd, rx_push, dma_on, char_timeout} = 6'h00;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(1);
    chk(fifo_mode, 0);
    chk(rx_trigger_level, 0);
    chk(fifo_enabled_status, 0);
    chk(dma_multi, 0);
    rd_reg(OFS_FIFO_CONTROL, rd);
    chk(rd, 0);
    rd_reg(8'h40, rd);
    chk(rd, 0);
    // Control bits without the enable bit are dropped
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_00CE);
    tick(2);
    chk({rx_trigger_level, dma_multi, fifo_mode}, 0);
    chk(n_txc + n_rxc, 0);
    // Enabling FIFO mode clears both FIFOs once
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_0001);
    tick(2);
    chk(fifo_mode, 1);
    chk(fifo_enabled_status, 2'b11);
    chk({n_txc[3:0], n_rxc[3:0]}, 8'h11);
    // Clear event raises the interrupt only when unmasked
    chk(irq, 0);
    wr_reg(OFS_INT_MASK, 32'h0000_0004);
    tick(1);
    chk(irq, 1);
    rd_reg(OFS_INT_STATUS, rd);
    chk(rd, 32'h0000_0004);
    wr_reg(OFS_INT_STATUS, 32'h0000_0004);
    tick(1);
    chk(irq, 0);
    rd_reg(OFS_INT_MASK, rd);
    chk(rd, 32'h0000_0004);
    // Single-character transmit DMA moves one byte only
    @(posedge sys_clk) dma_on <= 1'b1;
    tick(8);
    chk(tx_level, 1);
    @(posedge sys_clk) dma_on <= 1'b0;
    // Transmit then receive FIFO reset, each a single pulse
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_0005);
    tick(2);
    chk({n_txc[3:0], n_rxc[3:0]}, 8'h21);
    chk({tx_fifo_clear, tx_level}, 0);
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_0003);
    tick(2);
    chk({n_txc[3:0], n_rxc[3:0]}, 8'h22);
    chk(rx_fifo_clear, 0);
    // Multi-character mode; reserved bits read back as zero
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_0039);
    tick(2);
    chk(dma_multi, 1);
    rd_reg(OFS_FIFO_STATE, rd);
    chk(rd & 32'hFFFF_FFF8, 32'h0000_00C8);
    @(posedge sys_clk) dma_on <= 1'b1;
    tick(24);
    chk(tx_level, 5'h10);
    @(posedge sys_clk) dma_on <= 1'b0;
    // Every trigger selection, with burst drain of the receive FIFO
    for (int s = 0; s < 4; s++) begin
      wr_reg(OFS_FIFO_CONTROL, {24'h00_0000, s[1:0], 6'h0B});
      tick(2);
      chk(rx_trigger_level, s);
      push(thr[s] - 1);
      @(posedge sys_clk) dma_on <= 1'b1;
      tick(4);
      chk({rx_trigger_hit, rx_level}, thr[s] - 1);
      @(posedge sys_clk) dma_on <= 1'b0;
      push(1);
      tick(2);
      chk(rx_trigger_hit, 1);
      @(posedge sys_clk) dma_on <= 1'b1;
      tick(20);
      chk(rx_level, 0);
      @(posedge sys_clk) dma_on <= 1'b0;
    end
    // Character time-out starts a receive burst below the trigger
    push(1);
    @(posedge sys_clk) dma_on <= 1'b1;
    tick(4);
    chk(rx_level, 1);
    @(posedge sys_clk) char_timeout <= 1'b1;
    @(posedge sys_clk) char_timeout <= 1'b0;
    tick(6);
    chk(rx_level, 0);
    @(posedge sys_clk) dma_on <= 1'b0;
    // Trigger, time-out and clear events all left sticky status bits
    rd_reg(OFS_INT_STATUS, rd);
    chk(rd, 32'h0000_0007);
    // DMA bit clear: request follows any data at once
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_00C1);
    push(2);
    tick(1);
    chk({dma_multi, rx_dma_req, tx_dma_req}, 3'b010);
    // Disabling returns to single-character mode and clears
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_0000);
    tick(2);
    chk({fifo_mode, fifo_enabled_status}, 0);
    chk(rx_level, 0);
    // Reset in mid-run brings every setting back to its value after reset
    wr_reg(OFS_FIFO_CONTROL, 32'h0000_00C9);
    tick(1);
    chk(rx_trigger_level, 2'b11);
    @(posedge sys_clk) resetn <= 1'b0;
    tick(2);
    @(posedge sys_clk) resetn <= 1'b1;
    tick(2);
    chk({rx_trigger_level, dma_multi, fifo_mode, irq}, 0);
    wrap_up();
  end
endmodule
